// ### rtl/ebrg_arbiter.sv
// Contract
// - Request with no access underway: next cycle float bus, grant, halt.
// - Run-on mode grants likewise but halts only at next external access.
// - Request during an access: grant the cycle after the access ends.
// - Grant may fall mid-instruction, between two external accesses.
// - Request released: drop grant, drive bus again, resume where stopped.
// - Requests honoured during boot and processor reset too, but not under emulator halt.
// - Hung flag asserted when ready to execute but stalled by grant.
// - Request withdrawn while stalled: drop grant and hung, then access.
// - Emulation enable swaps in emulator reset, request, grant; floats grant.
// - Single-step or emulator halt ignores target reset and request.
`timescale 1ns/1ns
`default_nettype none

module ebrg_arbiter
  import ebrg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic bus_req_n_i,
  input wire logic proc_reset_n_i,
  input wire logic emu_enable_i,
  input wire logic emu_bus_req_n_i,
  input wire logic emu_reset_n_i,
  input wire logic emu_halted_i,
  input wire logic run_on_mode_i,
  input wire ebrg_core_in_t core_i,
  output ebrg_pins_t pins_o,
  output ebrg_core_out_t core_o
);

  // ****************************************************
  // Request synchronisation
  // ****************************************************
  logic [REQ_W-1:0] req_n_sync;
  logic req_sel;
  logic req_eff;
  logic granting;

  ebrg_sync #(
    .WIDTH(REQ_W),
    .RST_VAL(REQ_IDLE)
  ) u_req_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .d_i({emu_bus_req_n_i, bus_req_n_i}),
    .q_o(req_n_sync)
  );

  // Bit 1 is the emulator request, bit 0 the target request
  always_comb
  begin
    req_sel = emu_enable_i ? !req_n_sync[1] : !req_n_sync[0];
    req_eff = req_sel && !emu_halted_i;
  end

  // ****************************************************
  // State and registered outputs
  // ****************************************************
  ebrg_regs_t r_q;
  ebrg_regs_t r_d;

  always_comb
  begin
    r_d = r_q;
    granting = 1'h0;
    // Processor reset does not enter here, so arbitration continues through it
    unique case (r_q.st)
      ST_OWN:
      begin
        // An access in flight finishes first; its gap cycle is the slot
        if (req_eff && !core_i.acc_busy)
        begin
          r_d.st = ST_GRANT;
        end
      end
      ST_GRANT:
      begin
        if (!req_eff)
        begin
          r_d.st = ST_OWN;
        end
      end
    endcase
    granting = (r_d.st == ST_GRANT);

    r_d.core.drv_en = !granting;
    // Run-on keeps executing until the core asks for the bus
    r_d.core.halt = granting && (!run_on_mode_i || core_i.acc_want
                                 || r_q.core.halt);
    // No new access starts once a request is pending
    r_d.core.acc_allow = !granting && !req_eff;
    r_d.pins.bus_grant_hung_n =
      !(granting && r_d.core.halt && core_i.instr_ready);

    // Normal grant pin floats while the emulator owns the interface
    r_d.pins.bus_grant_n_oe = !emu_enable_i;
    r_d.pins.bus_grant_n = emu_enable_i ? LVL_INACTIVE_N : !granting;
    r_d.pins.emu_bus_grant_n = emu_enable_i ? !granting : LVL_INACTIVE_N;

    // Reset source follows emulation; frozen while emulator halts the core
    if (!emu_halted_i)
    begin
      r_d.core.core_reset_n = emu_enable_i ? emu_reset_n_i
                                           : proc_reset_n_i;
    end

    if (!rst_b_i)
    begin
      r_d.st = ST_OWN;
      r_d.pins.bus_grant_n = LVL_INACTIVE_N;
      r_d.pins.bus_grant_n_oe = DRV_ON;
      r_d.pins.emu_bus_grant_n = LVL_INACTIVE_N;
      r_d.pins.bus_grant_hung_n = LVL_INACTIVE_N;
      r_d.core.drv_en = DRV_ON;
      r_d.core.halt = 1'h0;
      r_d.core.acc_allow = 1'h0;
      // Core held in reset until the first selected level is sampled
      r_d.core.core_reset_n = 1'h0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    r_q <= r_d;
  end

  assign pins_o = r_q.pins;
  assign core_o = r_q.core;

  // ****************************************************
  // Checks
  // ****************************************************
  logic granted;
  assign granted = (r_q.st == ST_GRANT);

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  grant_on_idle_a: assert property (
    r_q.st == ST_OWN && req_eff && !core_i.acc_busy
    |=> granted && !core_o.drv_en
        && (pins_o.bus_grant_n == emu_enable_i ? 1'h1 : 1'h0)
        || !rst_b_i)
    else $error("grant did not follow an idle request");

  halt_no_runon_a: assert property (
    !run_on_mode_i && r_q.st == ST_OWN && req_eff && !core_i.acc_busy
    |=> core_o.halt)
    else $error("core not halted on grant");

  runon_keeps_a: assert property (
    granted && run_on_mode_i && !core_i.acc_want && !core_o.halt
    && req_eff |=> !core_o.halt)
    else $error("run-on mode halted without external access");

  wait_access_a: assert property (
    r_q.st == ST_OWN && core_i.acc_busy |=> !granted)
    else $error("grant during external access");

  no_start_pend_a: assert property (
    (req_eff || granting) |=> !core_o.acc_allow)
    else $error("access allowed while request pending");

  release_a: assert property (
    granted && !req_eff
    |=> !granted && core_o.drv_en && !core_o.halt
        && pins_o.bus_grant_hung_n)
    else $error("bus not returned on release");

  hung_cause_a: assert property (
    !pins_o.bus_grant_hung_n |-> granted && core_o.halt)
    else $error("hung flag without stalled grant");

  hung_set_a: assert property (
    req_eff && granted && !run_on_mode_i && core_i.instr_ready
    |=> !pins_o.bus_grant_hung_n)
    else $error("hung flag missing while stalled");

  emu_float_a: assert property (
    emu_enable_i |=> !pins_o.bus_grant_n_oe && pins_o.bus_grant_n)
    else $error("normal grant driven under emulation");

  emu_ignore_a: assert property (
    emu_halted_i && r_q.st == ST_OWN |=> !granted
    && $stable(core_o.core_reset_n))
    else $error("request or reset honoured under emulator halt");

  sync_lat_a: assert property (
    r_q.st == ST_OWN && !emu_enable_i && !emu_halted_i
    && $fell(bus_req_n_i) && !core_i.acc_busy
    |=> !granted)
    else $error("raw request seen before synchronisation");

  // ****************************************************
  // Pins and core outputs agree with the arbiter state
  // ****************************************************
  grant_pin_a: assert property (
    pins_o.bus_grant_n_oe
    |-> pins_o.bus_grant_n == !granted)
    else $error("grant pin disagrees with state");

  emu_pin_a: assert property (
    !pins_o.bus_grant_n_oe
    |-> pins_o.emu_bus_grant_n == !granted)
    else $error("emulator grant disagrees with state");

  emu_idle_a: assert property (
    pins_o.bus_grant_n_oe
    |-> pins_o.emu_bus_grant_n)
    else $error("emulator grant driven outside emulation");

  drv_off_a: assert property (
    granted
    |-> !core_o.drv_en)
    else $error("bus drivers on while granted");

  drv_match_a: assert property (
    !granted
    |-> core_o.drv_en)
    else $error("bus drivers off while owning the bus");

  halt_grant_a: assert property (
    core_o.halt
    |-> granted)
    else $error("core halted without a grant");

  acc_block_a: assert property (
    granted
    |-> !core_o.acc_allow)
    else $error("access allowed while granted");

  oe_follow_a: assert property (
    !emu_enable_i
    |=> pins_o.bus_grant_n_oe)
    else $error("grant pin floated outside emulation");

  // ****************************************************
  // Holding, releasing and stalling
  // ****************************************************
  grant_hold_a: assert property (
    granted && req_eff
    |=> granted)
    else $error("grant dropped while request held");

  allow_after_a: assert property (
    granted && !req_eff
    |=> core_o.acc_allow)
    else $error("access not allowed after release");

  halt_sticky_a: assert property (
    granted && req_eff && core_o.halt
    |=> core_o.halt)
    else $error("halt dropped while still granted");

  runon_want_a: assert property (
    granted && req_eff && core_i.acc_want
    |=> core_o.halt)
    else $error("run-on did not halt at external access");

  hung_ready_a: assert property (
    granted && req_eff && core_o.halt && !core_i.instr_ready
    |=> pins_o.bus_grant_hung_n)
    else $error("hung flag without ready instruction");

  hung_stall_a: assert property (
    granted && req_eff && core_o.halt && core_i.instr_ready
    |=> !pins_o.bus_grant_hung_n)
    else $error("hung flag missing while halted and ready");

  hung_clear_a: assert property (
    !pins_o.bus_grant_hung_n && !req_eff
    |=> pins_o.bus_grant_hung_n && pins_o.bus_grant_n)
    else $error("grant or hung kept after withdrawal");

  // ****************************************************
  // Reset sources and emulation
  // ****************************************************
  reset_emu_a: assert property (
    emu_enable_i && !emu_halted_i
    |=> core_o.core_reset_n == $past(emu_reset_n_i))
    else $error("emulator reset not used under emulation");

  reset_target_a: assert property (
    !emu_enable_i && !emu_halted_i
    |=> core_o.core_reset_n == $past(proc_reset_n_i))
    else $error("target reset not followed");

  prst_grant_a: assert property (
    r_q.st == ST_OWN && req_eff && !core_i.acc_busy && !core_o.core_reset_n
    |=> granted)
    else $error("request refused during processor reset");

  emu_release_a: assert property (
    emu_halted_i && granted
    |=> !granted)
    else $error("grant kept under emulator halt");

  emu_req_only_a: assert property (
    emu_enable_i && req_n_sync[1] && r_q.st == ST_OWN
    |=> !granted)
    else $error("target request honoured under emulation");

  emu_cov_c: cover property (
    !pins_o.bus_grant_n_oe && !pins_o.emu_bus_grant_n);
  grant_cov_c: cover property (granted ##1 !granted);
  runon_cov_c: cover property (
    granted && run_on_mode_i && !core_o.halt ##1 core_o.halt);
  hung_cov_c: cover property (!pins_o.bus_grant_hung_n);
  delay_cov_c: cover property (
    core_i.acc_busy && req_eff ##1 !core_i.acc_busy ##1 granted);

endmodule : ebrg_arbiter

`default_nettype wire

// ### rtl/ebrg_pkg.sv
package ebrg_pkg;

  // ****************************************************
  // Synchroniser and reset values
  // ****************************************************
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned REQ_W = 2;
  localparam logic [1:0] REQ_IDLE = 2'h3;
  localparam logic LVL_INACTIVE_N = 1'h1;
  localparam logic DRV_ON = 1'h1;

  // ****************************************************
  // Arbiter state
  // ****************************************************
  typedef enum logic [1:0] {
    ST_OWN = 2'h1,
    ST_GRANT = 2'h2
  } ebrg_state_t;

  // Core handshake towards the sequencer and memory interface
  typedef struct packed {
    logic acc_busy;
    logic acc_want;
    logic instr_ready;
  } ebrg_core_in_t;

  typedef struct packed {
    logic drv_en;
    logic halt;
    logic acc_allow;
    logic core_reset_n;
  } ebrg_core_out_t;

  // Pin group on the memory bus side
  typedef struct packed {
    logic bus_grant_n;
    logic bus_grant_n_oe;
    logic emu_bus_grant_n;
    logic bus_grant_hung_n;
  } ebrg_pins_t;

  typedef struct packed {
    ebrg_state_t st;
    ebrg_pins_t pins;
    ebrg_core_out_t core;
  } ebrg_regs_t;

endpackage : ebrg_pkg

// ### rtl/ebrg_sync.sv
`timescale 1ns/1ns
`default_nettype none

module ebrg_sync
  import ebrg_pkg::*;
#(
  parameter int unsigned WIDTH = REQ_W,
  parameter logic [WIDTH-1:0] RST_VAL = '1
)
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ebrg_sync_regs_t;

  ebrg_sync_regs_t r_q;
  ebrg_sync_regs_t r_d;

  // ****************************************************
  // Two flops; the first one feeds only the second
  // ****************************************************
  always_comb
  begin
    r_d = r_q;
    r_d.meta = d_i;
    r_d.stable = r_q.meta;
    if (!rst_b_i)
    begin
      r_d.meta = RST_VAL;
      r_d.stable = RST_VAL;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    r_q <= r_d;
  end

  assign q_o = r_q.stable;

endmodule : ebrg_sync

`default_nettype wire

// ### tb/ebrg_master_model.sv
`timescale 1ns/1ns
`default_nettype none

module ebrg_master_model (
  input wire logic sys_clk_i,
  input wire logic go_i,
  input wire logic [7:0] hold_i,
  input wire logic bus_grant_n_i,
  output logic bus_req_n_o,
  output logic bus_drive_o
);
  logic [7:0] cnt_q;

  // Request kept low until its own transfers are done
  assign bus_req_n_o = !go_i || cnt_q == hold_i;
  assign bus_drive_o = !bus_grant_n_i && !bus_req_n_o;

  always @(negedge sys_clk_i)
    if (!go_i)
      cnt_q <= 8'h00;
    else if (bus_drive_o)
      cnt_q <= cnt_q + 8'h01;
endmodule : ebrg_master_model

`default_nettype wire

// ### tb/external_bus_request_grant_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module external_bus_request_grant_tb_top
  import ebrg_pkg::*;
;
  logic clk = 1'h0, rst_b = 1'h0, go = 1'h0, run_on = 1'h0;
  logic emu_en = 1'h0, emu_req_n = 1'h1, emu_rst_n = 1'h1;
  logic emu_halt = 1'h0, prst_n = 1'h1, breq_n, drive;
  logic [7:0] hold = 8'h04;
  ebrg_core_in_t core = 3'h1;
  ebrg_pins_t pins;
  ebrg_core_out_t cout;
  int errors = 0, check_count = 0, n;

  always #2 clk = ~clk;

  ebrg_master_model u_master (.sys_clk_i(clk), .go_i(go), .hold_i(hold),
    .bus_grant_n_i(pins.bus_grant_n), .bus_req_n_o(breq_n),
    .bus_drive_o(drive));
  ebrg_arbiter u_dut (.sys_clk_i(clk), .rst_b_i(rst_b), .bus_req_n_i(breq_n),
    .proc_reset_n_i(prst_n), .emu_enable_i(emu_en),
    .emu_bus_req_n_i(emu_req_n), .emu_reset_n_i(emu_rst_n),
    .emu_halted_i(emu_halt), .run_on_mode_i(run_on), .core_i(core),
    .pins_o(pins), .core_o(cout));

  // ****************************************************
  // Helpers
  // ****************************************************
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic pick(input int sel);
    case (sel)
      0: return pins.bus_grant_n;
      1: return pins.emu_bus_grant_n;
      default: return breq_n;
    endcase
  endfunction : pick

  // Counts rising edges until the chosen signal reaches val
  task automatic wait_for(input int sel, input logic val);
    n = 0;
    while (pick(sel) !== val)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 60)
      begin
        errors++;
        final_report();
      end
    end
  endtask : wait_for

  // First edge after the pin rise is used up seeing the rise
  task automatic release_chk;
    wait_for(2, 1'h1);
    wait_for(0, 1'h1);
    chk(8'(n), 8'h02);
    chk({4'h0, cout.drv_en, cout.halt, cout.acc_allow,
      pins.bus_grant_hung_n}, 8'h0B);
    @(negedge clk) go <= 1'h0;
  endtask : release_chk

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_idle;
    @(negedge clk) go <= 1'h1;
    wait_for(0, 1'h0);
    chk(8'(n), 8'h03);
    chk({4'h0, cout.drv_en, cout.halt, cout.acc_allow,
      pins.bus_grant_hung_n}, 8'h04);
    @(posedge clk);
    #1 chk(8'(pins.bus_grant_hung_n), 8'h00);
    @(negedge clk) core.instr_ready <= 1'h0;
    @(posedge clk);
    #1 chk(8'(pins.bus_grant_hung_n), 8'h01);
    @(negedge clk) core.instr_ready <= 1'h1;
    release_chk();
    $display("t_idle done");
  endtask : t_idle

  task automatic t_busy;
    @(negedge clk);
    go <= 1'h1;
    core.acc_busy <= 1'h1;
    repeat (6) @(posedge clk);
    #1 chk({5'h00, pins.bus_grant_n, cout.acc_allow, drive},
      8'h04);
    @(negedge clk) core.acc_busy <= 1'h0;
    wait_for(0, 1'h0);
    chk(8'(n), 8'h01);
    release_chk();
    $display("t_busy done");
  endtask : t_busy

  task automatic t_run_on;
    @(negedge clk);
    run_on <= 1'h1;
    go <= 1'h1;
    wait_for(0, 1'h0);
    chk({6'h00, cout.drv_en, cout.halt}, 8'h00);
    @(posedge clk);
    #1 chk(8'(cout.halt), 8'h00);
    @(negedge clk) core.acc_want <= 1'h1;
    @(posedge clk);
    #1 chk(8'(cout.halt), 8'h01);
    release_chk();
    core.acc_want <= 1'h0;
    run_on <= 1'h0;
    $display("t_run_on done");
  endtask : t_run_on

  task automatic t_prst;
    @(negedge clk);
    prst_n <= 1'h0;
    go <= 1'h1;
    wait_for(0, 1'h0);
    chk(8'(n), 8'h03);
    chk(8'(cout.core_reset_n), 8'h00);
    release_chk();
    prst_n <= 1'h1;
    $display("t_prst done");
  endtask : t_prst

  task automatic t_emu;
    @(negedge clk) emu_en <= 1'h1;
    @(posedge clk);
    #1 chk({6'h00, pins.bus_grant_n_oe, pins.bus_grant_n}, 8'h01);
    @(negedge clk);
    emu_req_n <= 1'h0;
    emu_rst_n <= 1'h0;
    wait_for(1, 1'h0);
    chk(8'(n), 8'h03);
    chk({6'h00, pins.bus_grant_n, cout.core_reset_n}, 8'h02);
    @(negedge clk) emu_req_n <= 1'h1;
    wait_for(1, 1'h1);
    chk(8'(n), 8'h03);
    @(negedge clk);
    emu_rst_n <= 1'h1;
    emu_en <= 1'h0;
    $display("t_emu done");
  endtask : t_emu

  task automatic t_emu_halt;
    @(negedge clk);
    emu_halt <= 1'h1;
    prst_n <= 1'h0;
    go <= 1'h1;
    repeat (8) @(posedge clk);
    #1 chk({6'h00, pins.bus_grant_n, cout.core_reset_n}, 8'h03);
    @(negedge clk);
    emu_halt <= 1'h0;
    prst_n <= 1'h1;
    release_chk();
    $display("t_emu_halt done");
  endtask : t_emu_halt

  initial
  begin
    repeat (16) @(negedge clk);
    rst_b <= 1'h1;
    repeat (4) @(negedge clk);
    t_idle();
    t_busy();
    t_run_on();
    t_prst();
    t_emu();
    t_emu_halt();
    final_report();
  end
endmodule : external_bus_request_grant_tb_top

`default_nettype wire
